// ===== card_attribute_decoder.sv
`timescale 1ns/1ps
module card_attribute_decoder (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_b,
  input  wire logic [card_host_pkg::AXI_ADDR_W-1:0]  awaddr,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  input  wire logic [card_host_pkg::AXI_ADDR_W-1:0]  araddr,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  output logic [31:0]                                rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  output logic [card_host_pkg::CARD_ADDR_W-1:0]      cardAddr,
  output logic                                       cardCe1N,
  output logic                                       cardCe2N,
  output logic                                       cardRegN,
  output logic                                       cardOeN,
  output logic                                       cardWeN,
  input  wire logic [15:0]                           cardDataIn,
  output logic [15:0]                                cardDataOut,
  output logic                                       cardDataOe
);
  // ==========================================================================
  // Timing constants and checks
  localparam logic [card_host_pkg::CNT_W-1:0] SETUP_CNT =
    card_host_pkg::CNT_W'(card_host_pkg::SETUP_CYC - 1);
  localparam logic [card_host_pkg::CNT_W-1:0] STROBE_CNT =
    card_host_pkg::CNT_W'(card_host_pkg::STROBE_CYC - 1);
  localparam logic [card_host_pkg::CNT_W-1:0] HOLD_CNT =
    card_host_pkg::CNT_W'(card_host_pkg::HOLD_CYC - 1);
  localparam int SetupMax = card_host_pkg::SETUP_CYC + 1;

  // The read path needs two synchroniser cycles inside the strobe.
  if (card_host_pkg::STROBE_CYC < 3 || card_host_pkg::STROBE_CYC > 255 ||
      card_host_pkg::SETUP_CYC < 1 || card_host_pkg::HOLD_CYC < 1) begin : g_bad_timing
    $error("pin timing counts out of range");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    card_host_pkg::phase_t                  phase;
    logic [card_host_pkg::CNT_W-1:0]        cnt;
    logic [31:0]                            ctrl;
    logic [15:0]                            wrData;
    logic [15:0]                            rdData;
    logic                                   start;
    logic                                   done;
    logic                                   refused;
    logic                                   cfgHit;
    logic [2:0]                             cfgIdx;
    logic [15:0]                            mask;
    logic [card_host_pkg::CARD_ADDR_W-1:0]  pinAddr;
    logic                                   ce1N;
    logic                                   ce2N;
    logic                                   regN;
    logic                                   oeN;
    logic                                   weN;
    logic                                   dOe;
    logic [15:0]                            dOut;
    logic [15:0]                            sync1;
    logic [15:0]                            sync2;
    logic                                   bvalid;
    logic                                   rvalid;
    logic [1:0]                             bresp;
    logic [1:0]                             rresp;
    logic [31:0]                            rdBus;
  } state_t;

  localparam state_t RESET_STATE = '{phase: card_host_pkg::PH_IDLE, ce1N: 1'b1, ce2N: 1'b1,
                                     regN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};

  state_t      st_reg;
  state_t      st_next;
  logic        wrFire;
  logic        arFire;
  logic        busy;
  logic [2:0]  awIdx;
  logic [2:0]  arIdx;
  logic [31:0] ctrlNew;
  logic [31:0] statusWord;
  access_if    acc ();

  card_access_check u_check (
    .acc (acc.check)
  );

  assign acc.attrSpace = st_reg.ctrl[card_host_pkg::CTRL_ATTR_BIT];
  assign acc.writeDir  = st_reg.ctrl[card_host_pkg::CTRL_WR_BIT];
  assign acc.lane      = st_reg.ctrl[card_host_pkg::CTRL_LANE_MSB:card_host_pkg::CTRL_LANE_LSB];
  assign acc.addr      = st_reg.ctrl[card_host_pkg::CTRL_ADDR_MSB:card_host_pkg::CTRL_ADDR_LSB];

  // ==========================================================================
  // Bus slave handshakes
  assign awIdx   = awaddr[4:2];
  assign arIdx   = araddr[4:2];
  assign wrFire  = awvalid && wvalid && !st_reg.bvalid;
  assign arFire  = arvalid && !st_reg.rvalid;
  assign awready = wrFire;
  assign wready  = wrFire;
  assign arready = !st_reg.rvalid;
  assign busy    = (st_reg.phase != card_host_pkg::PH_IDLE) || st_reg.start;
  assign ctrlNew = card_host_pkg::mergeBytes(st_reg.ctrl, wdata, wstrb);

  always_comb begin
    statusWord = '0;
    statusWord[card_host_pkg::STAT_BUSY_BIT] = busy;
    statusWord[card_host_pkg::STAT_DONE_BIT] = st_reg.done;
    statusWord[card_host_pkg::STAT_REF_BIT]  = st_reg.refused;
    statusWord[card_host_pkg::STAT_CFG_BIT]  = st_reg.cfgHit;
    statusWord[card_host_pkg::STAT_IDX_MSB:card_host_pkg::STAT_IDX_LSB] = st_reg.cfgIdx;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = cardDataIn;
    st_next.sync2 = st_reg.sync1;
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (wrFire) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = card_host_pkg::RESP_OKAY;
      if (awIdx == card_host_pkg::REG_CTRL_IDX) begin
        // A new order while a cycle runs is dropped; software polls busy first.
        if (!busy) begin
          st_next.ctrl  = ctrlNew;
          st_next.start = ctrlNew[card_host_pkg::CTRL_GO_BIT];
          st_next.ctrl[card_host_pkg::CTRL_GO_BIT] = 1'b0;
        end
      end else if (awIdx == card_host_pkg::REG_WDATA_IDX) begin
        st_next.wrData = 16'(card_host_pkg::mergeBytes({16'h0000, st_reg.wrData}, wdata, wstrb));
      end else if (awIdx == card_host_pkg::REG_STATUS_IDX) begin
        if (wstrb[0] && wdata[card_host_pkg::STAT_DONE_BIT]) begin
          st_next.done = 1'b0;
        end
        if (wstrb[0] && wdata[card_host_pkg::STAT_REF_BIT]) begin
          st_next.refused = 1'b0;
        end
      end else if (awIdx != card_host_pkg::REG_RDATA_IDX) begin
        st_next.bresp = card_host_pkg::RESP_SLVERR;
      end
    end
    if (arFire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = card_host_pkg::RESP_OKAY;
      if (arIdx == card_host_pkg::REG_CTRL_IDX) begin
        st_next.rdBus = st_reg.ctrl;
      end else if (arIdx == card_host_pkg::REG_WDATA_IDX) begin
        st_next.rdBus = {16'h0000, st_reg.wrData};
      end else if (arIdx == card_host_pkg::REG_STATUS_IDX) begin
        st_next.rdBus = statusWord;
      end else if (arIdx == card_host_pkg::REG_RDATA_IDX) begin
        st_next.rdBus = {16'h0000, st_reg.rdData};
      end else begin
        st_next.rdBus = '0;
        st_next.rresp = card_host_pkg::RESP_SLVERR;
      end
    end

    // ========================================================================
    // Card cycle sequencer; its flag sets come last so a set beats a clear.
    unique case (st_reg.phase)
      card_host_pkg::PH_IDLE: begin
        if (st_reg.start) begin
          st_next.start = 1'b0;
          if (acc.legal) begin // R01 R05 R07 R09 R10
            st_next.pinAddr = acc.addr;
            st_next.ce1N    = acc.ce1N; // R06
            st_next.ce2N    = acc.ce2N;
            st_next.regN    = acc.regN; // R03 R08
            st_next.cfgHit  = acc.cfgHit; // R02
            st_next.cfgIdx  = acc.cfgIdx; // R04
            st_next.mask    = acc.laneMask;
            st_next.dOut    = st_reg.wrData;
            st_next.dOe     = acc.writeDir; // R13
            st_next.cnt     = SETUP_CNT;
            st_next.phase   = card_host_pkg::PH_SETUP;
          end else begin
            st_next.refused = 1'b1;
          end
        end
      end
      card_host_pkg::PH_SETUP: begin
        if (st_reg.cnt == '0) begin
          st_next.oeN   = st_reg.dOe; // R03 R07
          st_next.weN   = !st_reg.dOe;
          st_next.cnt   = STROBE_CNT;
          st_next.phase = card_host_pkg::PH_STROBE;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
      card_host_pkg::PH_STROBE: begin
        if (st_reg.cnt == '0) begin
          st_next.oeN = 1'b1;
          st_next.weN = 1'b1;
          if (!st_reg.dOe) begin
            st_next.rdData = st_reg.sync2 & st_reg.mask; // R11
          end
          st_next.cnt   = HOLD_CNT;
          st_next.phase = card_host_pkg::PH_HOLD;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
      card_host_pkg::PH_HOLD: begin
        if (st_reg.cnt == '0) begin
          st_next.ce1N  = 1'b1;
          st_next.ce2N  = 1'b1;
          st_next.regN  = 1'b1;
          st_next.dOe   = 1'b0; // R13
          st_next.done  = 1'b1;
          st_next.phase = card_host_pkg::PH_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bvalid      = st_reg.bvalid;
  assign bresp       = st_reg.bresp;
  assign rvalid      = st_reg.rvalid;
  assign rresp       = st_reg.rresp;
  assign rdata       = st_reg.rdBus;
  assign cardAddr    = st_reg.pinAddr;
  assign cardCe1N    = st_reg.ce1N;
  assign cardCe2N    = st_reg.ce2N;
  assign cardRegN    = st_reg.regN;
  assign cardOeN     = st_reg.oeN;
  assign cardWeN     = st_reg.weN;
  assign cardDataOut = st_reg.dOut;
  assign cardDataOe  = st_reg.dOe;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic strobeOn;
  assign strobeOn = !cardOeN || !cardWeN;

  property p_attrEven;
    (!cardRegN && strobeOn) |-> !cardAddr[0];
  endproperty
  a_attrEven: assert property (p_attrEven) else $error("odd attribute address"); // R01

  property p_attrLane;
    (!cardRegN && strobeOn) |-> (!cardCe1N && cardCe2N);
  endproperty
  a_attrLane: assert property (p_attrLane) else $error("attribute lane not low"); // R10

  property p_oneStrobe;
    !(!cardOeN && !cardWeN);
  endproperty
  a_oneStrobe: assert property (p_oneStrobe) else $error("both strobes low"); // R03

  property p_wordEven;
    (!cardCe1N && !cardCe2N && strobeOn) |-> !cardAddr[0];
  endproperty
  a_wordEven: assert property (p_wordEven) else $error("odd word access"); // R05

  property p_writeDrive;
    !cardWeN |-> (cardOeN && cardDataOe);
  endproperty
  a_writeDrive: assert property (p_writeDrive) else $error("write without data drive"); // R07

  property p_noCisWrite;
    (!cardRegN && !cardWeN) |-> (cardAddr[10:9] != card_host_pkg::SPACE_CIS);
  endproperty
  a_noCisWrite: assert property (p_noCisWrite) else $error("write to info structure"); // R09

  property p_readBusFree;
    (!cardOeN || $fell(cardOeN)) |-> !cardDataOe;
  endproperty
  a_readBusFree: assert property (p_readBusFree) else $error("bus driven during read"); // R13

  property p_cfgMap;
    (st_reg.phase == card_host_pkg::PH_STROBE && st_reg.cfgHit) |->
      (!cardRegN && cardAddr[10:9] == card_host_pkg::SPACE_CFG &&
       st_reg.cfgIdx == cardAddr[3:1]);
  endproperty
  a_cfgMap: assert property (p_cfgMap) else $error("config decode mismatch"); // R02 R04

  sequence s_goLegal;
    st_reg.phase == card_host_pkg::PH_IDLE && st_reg.start && acc.legal;
  endsequence
  sequence s_strobeSoon;
    ##[1:SetupMax] strobeOn;
  endsequence
  property p_goStrobe;
    s_goLegal |-> s_strobeSoon;
  endproperty
  a_goStrobe: assert property (p_goStrobe) else $error("strobe late after go"); // R03

  property p_goRefused;
    (st_reg.phase == card_host_pkg::PH_IDLE && st_reg.start && !acc.legal) |=>
      (st_reg.refused && cardCe1N && cardCe2N && cardOeN && cardWeN);
  endproperty
  a_goRefused: assert property (p_goRefused) else $error("illegal order reached pins"); // R10
endmodule

// ===== card_host_pkg.sv
// Functional notes
// R01: Attribute accesses are byte-wide at even addresses, data on lane D7-D0.
// R02: Configuration registers sit at attribute address 200h: A10 low, A9 high.
// R03: Config access: CE1, REG low, A10 low, A9 high, A8-A4 zero, A0 low.
// R04: Card decodes A3-A1 within configuration group to pick one of four registers.
// R05: Word common read needs REG high, both enables low, A0 low, OE low.
// R06: One enable low gives byte common access: CE1 low lane, CE2 high lane.
// R07: Common writes mirror reads with WE low, OE high; word writes need A0 low.
// R08: Attribute read at A10, A9 low returns card info structure bytes.
// R09: A write to the card info structure region is invalid.
// R10: Odd attribute address or CE2 alone with REG low is invalid.
// R11: Word attribute access: even byte on D7-D0, upper lane not valid.
// R12: Extended card variant decodes configuration access regardless of A10 and A9.
// R13: Data drivers stay released except while the driving side owns the bus.
package card_host_pkg;

  // ==========================================================================
  // Register map
  localparam int          AXI_ADDR_W     = 5;
  localparam logic [2:0]  REG_CTRL_IDX   = 3'h0;
  localparam logic [2:0]  REG_WDATA_IDX  = 3'h1;
  localparam logic [2:0]  REG_STATUS_IDX = 3'h2;
  localparam logic [2:0]  REG_RDATA_IDX  = 3'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // Control and status word fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_ADDR_MSB = 10;
  localparam int CTRL_ATTR_BIT = 16;
  localparam int CTRL_WR_BIT   = 17;
  localparam int CTRL_LANE_LSB = 18;
  localparam int CTRL_LANE_MSB = 19;
  localparam int CTRL_GO_BIT   = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REF_BIT  = 2;
  localparam int STAT_CFG_BIT  = 3;
  localparam int STAT_IDX_LSB  = 4;
  localparam int STAT_IDX_MSB  = 6;

  // ==========================================================================
  // Lanes and card address decode
  localparam int          CARD_ADDR_W = 11;
  localparam logic [1:0]  LANE_LOW    = 2'h0;
  localparam logic [1:0]  LANE_HIGH   = 2'h1;
  localparam logic [1:0]  LANE_WORD   = 2'h2;
  localparam logic [1:0]  SPACE_CIS   = 2'h0;
  localparam logic [1:0]  SPACE_CFG   = 2'h1;
  localparam logic [4:0]  CFG_MID     = 5'h00;
  localparam logic [15:0] MASK_LOW    = 16'h00ff;
  localparam logic [15:0] MASK_HIGH   = 16'hff00;
  localparam logic [15:0] MASK_WORD   = 16'hffff;

  // ==========================================================================
  // Pin timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_SETUP_NS = 30;
  localparam int STROBE_NS     = 150;
  localparam int ADDR_HOLD_NS  = 20;
  localparam int SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ===== access_if.sv
`timescale 1ns/1ps
interface access_if;
  logic                                 attrSpace;
  logic                                 writeDir;
  logic [1:0]                           lane;
  logic [card_host_pkg::CARD_ADDR_W-1:0] addr;
  logic                                 legal;
  logic                                 ce1N;
  logic                                 ce2N;
  logic                                 regN;
  logic                                 cfgHit;
  logic [2:0]                           cfgIdx;
  logic [15:0]                          laneMask;

  modport check (input attrSpace, writeDir, lane, addr,
                 output legal, ce1N, ce2N, regN, cfgHit, cfgIdx, laneMask);
  modport seq   (output attrSpace, writeDir, lane, addr,
                 input legal, ce1N, ce2N, regN, cfgHit, cfgIdx, laneMask);
endinterface

// ===== card_access_check.sv
`timescale 1ns/1ps
module card_access_check (
  access_if.check acc
);
  // ==========================================================================
  // Access classification
  logic attrOk;
  logic commonOk;
  logic cisWrite;

  // Refusing bad cycles here keeps the card from ever seeing an invalid access.
  assign cisWrite = acc.writeDir && (acc.addr[10:9] == card_host_pkg::SPACE_CIS); // R09
  assign attrOk   = (acc.lane == card_host_pkg::LANE_LOW) && !acc.addr[0] && !cisWrite; // R01 R10
  assign commonOk = (acc.lane == card_host_pkg::LANE_LOW) ||
                    (acc.lane == card_host_pkg::LANE_HIGH) ||
                    ((acc.lane == card_host_pkg::LANE_WORD) && !acc.addr[0]); // R05 R07
  assign acc.legal = acc.attrSpace ? attrOk : commonOk;

  assign acc.ce1N = !((acc.lane == card_host_pkg::LANE_LOW) ||
                      (acc.lane == card_host_pkg::LANE_WORD)); // R06
  assign acc.ce2N = !((acc.lane == card_host_pkg::LANE_HIGH) ||
                      (acc.lane == card_host_pkg::LANE_WORD)); // R06
  assign acc.regN = !acc.attrSpace;

  assign acc.cfgHit = acc.attrSpace && (acc.addr[10:9] == card_host_pkg::SPACE_CFG) &&
                      (acc.addr[8:4] == card_host_pkg::CFG_MID); // R02 R03
  assign acc.cfgIdx = acc.addr[3:1]; // R04

  // Attribute data live on the low lane only, so the upper byte is masked.
  assign acc.laneMask = (acc.attrSpace || acc.lane == card_host_pkg::LANE_LOW) ?
                        card_host_pkg::MASK_LOW :
                        (acc.lane == card_host_pkg::LANE_HIGH) ?
                        card_host_pkg::MASK_HIGH : card_host_pkg::MASK_WORD; // R11
endmodule

// ===== card_model.sv
`timescale 1ns/1ps
module card_model #(
  parameter bit extVariant = 1'b0
) (
  input  wire logic [10:0] addr,
  input  wire logic        ce1N,
  input  wire logic        ce2N,
  input  wire logic        regN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [15:0] dataOut,
  input  wire logic        dataOe,
  output logic      [15:0] dataIn
);
  // ==========================================================================
  // Storage and decode
  logic [7:0]  cfgRegs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  mem [32] = '{default: 8'h00};
  logic [15:0] lastData = 16'h0000;
  logic [15:0] rdVal;
  logic [7:0]  cisByte;
  logic        cfgSel;
  logic        cisSel;
  logic        rdOk;
  assign cfgSel  = !regN && !ce1N && !addr[0] && addr[8:3] == 6'h00 &&
                   (extVariant || addr[10:9] == 2'b01);
  assign cisSel  = !regN && !ce1N && addr[10:9] == 2'b00 && !addr[0];
  assign cisByte = 8'hc0 ^ addr[8:1];
  // Odd or high-lane-only attribute cycles select nothing, so nothing answers.
  assign rdOk = !oeN && weN && (regN ? !(ce1N && ce2N) : (cfgSel || cisSel));
  always_comb begin
    if (regN && !ce1N && !ce2N) begin
      rdVal = {mem[{addr[4:1], 1'b1}], mem[{addr[4:1], 1'b0}]};
    end else if (regN && !ce1N) begin
      rdVal = {~lastData[15:8], mem[addr[4:0]]};
    end else if (regN) begin
      rdVal = {mem[{addr[4:1], 1'b1}], ~lastData[7:0]};
    end else if (cfgSel) begin
      rdVal = {~cfgRegs[addr[2:1]], cfgRegs[addr[2:1]]};
    end else begin
      rdVal = {~cisByte, cisByte};
    end
  end
  // A released bus shows the inverse of its last value, so stale data cannot pass.
  assign dataIn = rdOk ? rdVal : ~lastData;
  always @(posedge oeN) begin
    lastData <= rdVal;
  end
  always @(posedge weN) begin
    if (regN) begin
      if (!ce1N && (ce2N || !addr[0])) begin
        mem[ce2N ? addr[4:0] : {addr[4:1], 1'b0}] <= dataOut[7:0];
      end
      if (!ce2N && (ce1N || !addr[0])) begin
        mem[{addr[4:1], 1'b1}] <= dataOut[15:8];
      end
    end else if (cfgSel) begin
      cfgRegs[addr[2:1]] <= dataOut[7:0];
    end
  end
endmodule

// ===== card_attribute_decoder_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module card_attribute_decoder_tb;
  // ==========================================================================
  // Signals
  localparam logic [4:0] A_CTRL = {card_host_pkg::REG_CTRL_IDX, 2'b00};
  localparam logic [4:0] A_WD   = {card_host_pkg::REG_WDATA_IDX, 2'b00};
  localparam logic [4:0] A_ST   = {card_host_pkg::REG_STATUS_IDX, 2'b00};
  localparam logic [4:0] A_RD   = {card_host_pkg::REG_RDATA_IDX, 2'b00};
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic [4:0]  awaddr   = 5'h00;
  logic [4:0]  araddr   = 5'h00;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'hf;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b1;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] cardAddr;
  logic        cardCe1N, cardCe2N, cardRegN, cardOeN, cardWeN, cardDataOe;
  logic [15:0] cardDataIn, cardDataOut;
  logic        pinSeen  = 1'b0;
  int          errors   = 0;
  int          n_checks = 0;

  card_attribute_decoder uut (.core_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .cardAddr, .cardCe1N, .cardCe2N, .cardRegN, .cardOeN, .cardWeN,
    .cardDataIn, .cardDataOut, .cardDataOe);
  card_model card (.addr(cardAddr), .ce1N(cardCe1N), .ce2N(cardCe2N), .regN(cardRegN),
    .oeN(cardOeN), .weN(cardWeN), .dataOut(cardDataOut), .dataOe(cardDataOe),
    .dataIn(cardDataIn));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (!cardCe1N || !cardCe2N) begin
      pinSeen <= 1'b1;
    end
  end
  always @(negedge core_clk) begin
    if (rst_b && !cardOeN) begin
      `CHK("read drive", 1'b0, cardDataOe)
    end
    if (rst_b && !cardWeN) begin
      `CHK("write drive", 1'b1, cardDataOe)
    end
  end

  // ==========================================================================
  // Bus and access tasks
  task automatic axiWrite(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    pa = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (pa && awready === 1'b1 && wready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end else if (!pa && bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end while (1);
  endtask
  task automatic axiRead(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa;
    pa = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (pa && arready === 1'b1) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end else if (!pa && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        break;
      end
    end while (1);
  endtask
  function automatic logic [31:0] mk(input logic [10:0] a, input logic at, input logic wr,
                                     input logic [1:0] ln);
    return 32'h8000_0000 | {12'h000, ln, wr, at, 5'h00, a};
  endfunction
  task automatic doAccess(input logic [31:0] c, input logic [15:0] wd, output logic [31:0] st,
                          output logic [31:0] rd);
    logic [1:0] r;
    int n;
    axiWrite(A_WD, {16'h0000, wd}, r);
    axiWrite(A_CTRL, c, r);
    st = 32'h0;
    for (n = 0; n < 60 && !(st[1] || st[2]); n++) begin
      axiRead(A_ST, st, r);
    end
    `CHK("finished", 1'b1, st[1] || st[2])
    axiRead(A_RD, rd, r);
    axiWrite(A_ST, 32'h6, r);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_cfg();
    logic [31:0] st, rd;
    logic [10:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 11'h200 | {8'h00, i[1:0], 1'b0};
      doAccess(mk(a, 1'b1, 1'b1, card_host_pkg::LANE_LOW), 16'hab30 + 16'(i), st, rd);
      `CHK("cfg write", 8'h30 + 8'(i), card.cfgRegs[i])
      doAccess(mk(a, 1'b1, 1'b0, card_host_pkg::LANE_LOW), 16'h0000, st, rd);
      `CHK("cfg read", 32'h30 + 32'(i), rd)
      `CHK("cfg hit", 1'b1, st[3])
      `CHK("cfg index", 3'(i), st[6:4])
    end
    doAccess(mk(11'h210, 1'b1, 1'b0, card_host_pkg::LANE_LOW), 16'h0000, st, rd);
    `CHK("cfg miss", 1'b0, st[3])
    $display("test cfg done");
  endtask
  task automatic t_common();
    logic [31:0] st, rd;
    doAccess(mk(11'h006, 1'b0, 1'b1, card_host_pkg::LANE_WORD), 16'h1234, st, rd);
    doAccess(mk(11'h009, 1'b0, 1'b1, card_host_pkg::LANE_LOW), 16'h55ee, st, rd);
    doAccess(mk(11'h00a, 1'b0, 1'b1, card_host_pkg::LANE_HIGH), 16'h7766, st, rd);
    `CHK("low byte mem", 8'hee, card.mem[9])
    doAccess(mk(11'h006, 1'b0, 1'b0, card_host_pkg::LANE_WORD), 16'h0000, st, rd);
    `CHK("word read", 32'h1234, rd)
    doAccess(mk(11'h009, 1'b0, 1'b0, card_host_pkg::LANE_LOW), 16'h0000, st, rd);
    `CHK("low read", 32'h00ee, rd)
    doAccess(mk(11'h00a, 1'b0, 1'b0, card_host_pkg::LANE_HIGH), 16'h0000, st, rd);
    `CHK("high read", 32'h7700, rd)
    $display("test common done");
  endtask
  task automatic t_cis();
    logic [31:0] st, rd;
    doAccess(mk(11'h004, 1'b1, 1'b0, card_host_pkg::LANE_LOW), 16'h0000, st, rd);
    `CHK("info read", 32'hc2, rd)
    pinSeen = 1'b0;
    doAccess(mk(11'h004, 1'b1, 1'b1, card_host_pkg::LANE_LOW), 16'h00aa, st, rd);
    `CHK("info write refused", 1'b1, st[2])
    `CHK("info write pins", 1'b0, pinSeen)
    $display("test info done");
  endtask
  task automatic t_bad();
    logic [31:0] st, rd;
    logic [31:0] tbl [6];
    tbl = '{mk(11'h201, 1'b1, 1'b0, 2'h0), mk(11'h203, 1'b1, 1'b1, 2'h0),
            mk(11'h202, 1'b1, 1'b1, 2'h1), mk(11'h202, 1'b1, 1'b0, 2'h2),
            mk(11'h007, 1'b0, 1'b0, 2'h2), mk(11'h002, 1'b0, 1'b0, 2'h3)};
    foreach (tbl[k]) begin
      pinSeen = 1'b0;
      doAccess(tbl[k], 16'h00ff, st, rd);
      `CHK("refused", 2'b10, st[2:1])
      `CHK("no pins", 1'b0, pinSeen)
    end
    `CHK("cfg kept", 8'h31, card.cfgRegs[1])
    $display("test refused done");
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    `CHK("idle ce", 2'b11, {cardCe1N, cardCe2N})
    `CHK("idle strobes", 3'b111, {cardRegN, cardOeN, cardWeN})
    `CHK("idle drive", 1'b0, cardDataOe)
    axiRead(A_ST, d, r);
    `CHK("status reset", 32'h0, d)
    axiRead(5'h10, d, r);
    `CHK("unmapped read", card_host_pkg::RESP_SLVERR, r)
    axiWrite(5'h14, 32'h1, r);
    `CHK("unmapped write", card_host_pkg::RESP_SLVERR, r)
    $display("test bus done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Each carried-out access costs about twenty-two cycles, a refused one ten; the limit leaves ample margin.
  initial begin
    #(20 * 20000);
    errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_bus();
    t_cfg();
    t_common();
    t_cis();
    t_bad();
    results();
  end
endmodule
